// File: pcc_pkg.sv
// Package with register map, field positions and reset values of the card configuration registers.
package pcc_pkg;
   localparam logic [10:0] ADDR_OPTION      = 11'h7F0;
   localparam logic [10:0] ADDR_STATUS      = 11'h7F2;
   localparam logic [7:0]  OPTION_RESET     = 8'h40;
   localparam logic [7:0]  STATUS_RESET     = 8'h00;
   localparam int          BIT_SOFT_RESET   = 7;
   localparam int          BIT_LEVEL_IRQ    = 6;
   localparam int          IDX_MSB          = 5;
   localparam int          BIT_CHANGED      = 7;
   localparam int          BIT_BYTE_IO      = 5;
   localparam int          BIT_POWER_DOWN   = 2;
   localparam logic [5:0]  IDX_RESET        = 6'h00;
   localparam logic [7:0]  STATUS_UNUSED    = 8'h5B;
   typedef enum logic [1:0] {PCC_RUN, PCC_STANDBY, PCC_SHUTDOWN} pcc_power_t;
endpackage

// File: pcc_bit_reg.sv
// Resettable register slice with write enable and synchronous soft clear.
`timescale 1ns/10ps
module pcc_bit_reg #(
   parameter int              WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input  wire logic             i_sys_clk,
   input  wire logic             i_reset,
   input  wire logic             i_clear,
   input  wire logic             i_we,
   input  wire logic [WIDTH-1:0] i_d,
   output logic      [WIDTH-1:0] o_q
);
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         o_q <= INIT;
      end else if (i_clear) begin
         o_q <= INIT;
      end else if (i_we) begin
         o_q <= i_d;
      end
   end
endmodule // pcc_bit_reg

// File: pcc_config_regs.sv
// Card configuration option and status registers reached through attribute memory.
// Operation
// - While soft reset bit is 1, device is held as if in hardware reset.
// - Soft reset also resets LAN core pointers and registers.
// - Writing soft reset 0 leaves reset in the post hardware reset state.
// - Level interrupt indicator bit 6 reads 1 in I/O mode, ignores writes.
// - Option bits 5..0 are a writable readable configuration index.
// - Status bit 7 mirrors pin replacement bit 5, ignores writes.
// - Status bits 6, 4, 3 read 0 and ignore writes.
// - Status bits 1, 0 read 0 and ignore writes.
// - Byte I/O select 0 gives word transfers and clears LAN byte width bit.
// - Byte I/O select 1 gives byte transfers and sets LAN byte width bit.
// - Clearing power down request ends standby, standby bit goes 1; shutdown is kept.
// - Setting power down request drives standby bit 0, entering standby.
// - With buffer management bit 4 set, power down enters shutdown instead.
// - Accesses use even addresses and low data byte; odd addresses invalid.
// - State change flag shows the ready busy bit toggled.
`timescale 1ns/10ps
module pcc_config_regs
   import pcc_pkg::*;
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_reset,
   input  wire logic [10:0] i_attr_addr,
   input  wire logic        i_attr_write,
   input  wire logic [7:0]  i_attr_wdata,
   input  wire logic        i_io_card_mode,
   input  wire logic        i_ready_busy_change_flag,
   input  wire logic        i_shutdown_enable,
   output logic      [7:0]  o_attr_rdata,
   output logic             o_core_reset,
   output logic             o_lan_byte_width_bit,
   output logic             o_lan_standby_bit,
   output logic             o_shutdown,
   output logic      [5:0]  o_config_index_field,
   output logic             o_byte_io_select
);
   ////////////////////////////////////////////////////////////////////////////
   logic       soft_reset_bit;
   logic [5:0] config_index_field;
   logic       byte_io_select;
   logic       power_down_request;
   pcc_power_t power_state;
   pcc_power_t next_power_state;
   logic [7:0] next_rdata;

   // Odd addresses never decode, so they neither write nor read a register.
   wire sel_option = (i_attr_addr == ADDR_OPTION);
   wire sel_status = (i_attr_addr == ADDR_STATUS);
   wire wr_option  = i_attr_write && sel_option;
   wire wr_status  = i_attr_write && sel_status;
   // The reset bit stays writable during soft reset so the host can release it.
   wire soft_hold  = soft_reset_bit;
   wire level_irq_indicator = i_io_card_mode;

   ////////////////////////////////////////////////////////////////////////////
   pcc_bit_reg #(.WIDTH(1), .INIT(OPTION_RESET[BIT_SOFT_RESET])) u_srst (
      .i_sys_clk (i_sys_clk),
      .i_reset   (i_reset),
      .i_clear   (1'h0),
      .i_we      (wr_option),
      .i_d       (i_attr_wdata[BIT_SOFT_RESET]),
      .o_q       (soft_reset_bit)
   );
   pcc_bit_reg #(.WIDTH(6), .INIT(IDX_RESET)) u_index (
      .i_sys_clk (i_sys_clk),
      .i_reset   (i_reset),
      .i_clear   (soft_hold),
      .i_we      (wr_option),
      .i_d       (i_attr_wdata[IDX_MSB:0]),
      .o_q       (config_index_field)
   );
   pcc_bit_reg #(.WIDTH(1), .INIT(STATUS_RESET[BIT_BYTE_IO])) u_byte (
      .i_sys_clk (i_sys_clk),
      .i_reset   (i_reset),
      .i_clear   (soft_hold),
      .i_we      (wr_status),
      .i_d       (i_attr_wdata[BIT_BYTE_IO]),
      .o_q       (byte_io_select)
   );
   pcc_bit_reg #(.WIDTH(1), .INIT(STATUS_RESET[BIT_POWER_DOWN])) u_pwr (
      .i_sys_clk (i_sys_clk),
      .i_reset   (i_reset),
      .i_clear   (soft_hold),
      .i_we      (wr_status),
      .i_d       (i_attr_wdata[BIT_POWER_DOWN]),
      .o_q       (power_down_request)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Shutdown stops the oscillator, so only a reset may leave it.
   always_comb begin
      next_power_state = power_state;
      case (power_state)
         PCC_RUN: begin
            if (power_down_request) begin
               next_power_state = i_shutdown_enable ? PCC_SHUTDOWN : PCC_STANDBY;
            end
         end
         PCC_STANDBY: begin
            if (!power_down_request) begin
               next_power_state = PCC_RUN;
            end
         end
         PCC_SHUTDOWN: begin
            next_power_state = PCC_SHUTDOWN;
         end
         default: begin
            next_power_state = PCC_RUN;
         end
      endcase
      if (soft_hold) begin
         next_power_state = PCC_RUN;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         power_state <= PCC_RUN;
      end else begin
         power_state <= next_power_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   wire [7:0] option_view = {soft_reset_bit, level_irq_indicator, config_index_field};
   wire [7:0] status_view = {i_ready_busy_change_flag, 1'h0, byte_io_select, 2'h0,
                             power_down_request, 2'h0};

   assign next_rdata = sel_option ? option_view :
                       sel_status ? status_view : 8'h00;

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         o_attr_rdata <= 8'h00;
      end else begin
         o_attr_rdata <= next_rdata;
      end
   end

   assign o_core_reset         = soft_hold;
   assign o_lan_byte_width_bit = byte_io_select;
   assign o_lan_standby_bit    = (power_state == PCC_RUN);
   assign o_shutdown           = (power_state == PCC_SHUTDOWN);
   assign o_config_index_field = config_index_field;
   assign o_byte_io_select     = byte_io_select;

   ////////////////////////////////////////////////////////////////////////////
   property p_soft_clears;
      @(posedge i_sys_clk) disable iff (i_reset)
      soft_reset_bit |=> (config_index_field == IDX_RESET) && !byte_io_select && !power_down_request;
   endproperty
   a_soft_clears: assert property (p_soft_clears) else $error("Soft reset did not clear state.");

   property p_core_reset;
      @(posedge i_sys_clk) disable iff (i_reset)
      (wr_option && i_attr_wdata[BIT_SOFT_RESET]) |=> o_core_reset;
   endproperty
   a_core_reset: assert property (p_core_reset) else $error("Core reset not raised.");

   property p_release;
      @(posedge i_sys_clk) disable iff (i_reset)
      (soft_reset_bit && wr_option && !i_attr_wdata[BIT_SOFT_RESET]) |=> !o_core_reset && o_lan_standby_bit;
   endproperty
   a_release: assert property (p_release) else $error("Soft reset release failed.");

   property p_level_read;
      @(posedge i_sys_clk) disable iff (i_reset)
      (sel_option && i_io_card_mode) |=> o_attr_rdata[BIT_LEVEL_IRQ];
   endproperty
   a_level_read: assert property (p_level_read) else $error("Level interrupt bit read wrong.");

   property p_index_write;
      @(posedge i_sys_clk) disable iff (i_reset)
      (wr_option && !soft_reset_bit) |=> (config_index_field == $past(i_attr_wdata[IDX_MSB:0]));
   endproperty
   a_index_write: assert property (p_index_write) else $error("Index not stored.");

   property p_status_zero;
      @(posedge i_sys_clk) disable iff (i_reset)
      sel_status |=> ((o_attr_rdata & STATUS_UNUSED) == 8'h00);
   endproperty
   a_status_zero: assert property (p_status_zero) else $error("Unused status bits not zero.");

   property p_changed;
      @(posedge i_sys_clk) disable iff (i_reset)
      sel_status |=> (o_attr_rdata[BIT_CHANGED] == $past(i_ready_busy_change_flag));
   endproperty
   a_changed: assert property (p_changed) else $error("Changed bit does not mirror flag.");

   property p_width;
      @(posedge i_sys_clk) disable iff (i_reset)
      (wr_status && !soft_reset_bit) |=> (o_lan_byte_width_bit == $past(i_attr_wdata[BIT_BYTE_IO]));
   endproperty
   a_width: assert property (p_width) else $error("Byte width bit wrong.");

   property p_standby;
      @(posedge i_sys_clk) disable iff (i_reset)
      (wr_status && !soft_reset_bit && i_attr_wdata[BIT_POWER_DOWN] && power_state == PCC_RUN)
         |=> ##1 !o_lan_standby_bit;
   endproperty
   a_standby: assert property (p_standby) else $error("Standby not entered.");

   property p_wake;
      @(posedge i_sys_clk) disable iff (i_reset)
      (power_state == PCC_STANDBY && !power_down_request && !soft_reset_bit) |=> o_lan_standby_bit;
   endproperty
   a_wake: assert property (p_wake) else $error("Standby not left.");

   property p_shutdown;
      @(posedge i_sys_clk) disable iff (i_reset)
      (power_state == PCC_RUN && power_down_request && i_shutdown_enable && !soft_reset_bit) |=> o_shutdown;
   endproperty
   a_shutdown: assert property (p_shutdown) else $error("Shutdown not entered.");

   property p_odd;
      @(posedge i_sys_clk) disable iff (i_reset)
      i_attr_addr[0] |=> (o_attr_rdata == 8'h00);
   endproperty
   a_odd: assert property (p_odd) else $error("Odd address returned data.");

   property p_level_off;
      @(posedge i_sys_clk) disable iff (i_reset)
      (sel_option && !i_io_card_mode) |=> !o_attr_rdata[BIT_LEVEL_IRQ];
   endproperty
   a_level_off: assert property (p_level_off) else $error("Level bit set outside I/O mode.");

   property p_index_read;
      @(posedge i_sys_clk) disable iff (i_reset)
      sel_option |=> (o_attr_rdata[IDX_MSB:0] == $past(config_index_field));
   endproperty
   a_index_read: assert property (p_index_read) else $error("Index read back wrong.");

   property p_soft_read;
      @(posedge i_sys_clk) disable iff (i_reset)
      sel_option |=> (o_attr_rdata[BIT_SOFT_RESET] == $past(soft_reset_bit));
   endproperty
   a_soft_read: assert property (p_soft_read) else $error("Soft reset bit read back wrong.");

   property p_byte_read;
      @(posedge i_sys_clk) disable iff (i_reset)
      sel_status |=> (o_attr_rdata[BIT_BYTE_IO] == $past(byte_io_select));
   endproperty
   a_byte_read: assert property (p_byte_read) else $error("Byte select read back wrong.");

   property p_power_read;
      @(posedge i_sys_clk) disable iff (i_reset)
      sel_status |=> (o_attr_rdata[BIT_POWER_DOWN] == $past(power_down_request));
   endproperty
   a_power_read: assert property (p_power_read) else $error("Power down bit read back wrong.");

   property p_soft_power;
      @(posedge i_sys_clk) disable iff (i_reset)
      soft_reset_bit |=> o_lan_standby_bit && !o_shutdown;
   endproperty
   a_soft_power: assert property (p_soft_power) else $error("Soft reset left power down active.");

   property p_soft_keep;
      @(posedge i_sys_clk) disable iff (i_reset)
      (soft_reset_bit && !wr_option) |=> soft_reset_bit;
   endproperty
   a_soft_keep: assert property (p_soft_keep) else $error("Soft reset bit lost its value.");

   property p_shutdown_keep;
      @(posedge i_sys_clk) disable iff (i_reset)
      (o_shutdown && !soft_reset_bit) |=> o_shutdown;
   endproperty
   a_shutdown_keep: assert property (p_shutdown_keep) else $error("Shutdown left without reset.");

   property p_width_keep;
      @(posedge i_sys_clk) disable iff (i_reset)
      (!wr_status && !soft_reset_bit) |=> $stable(o_lan_byte_width_bit);
   endproperty
   a_width_keep: assert property (p_width_keep) else $error("Byte width bit changed unasked.");

   property p_index_keep;
      @(posedge i_sys_clk) disable iff (i_reset)
      (!wr_option && !soft_reset_bit) |=> $stable(config_index_field);
   endproperty
   a_index_keep: assert property (p_index_keep) else $error("Index changed unasked.");

   property p_unmapped;
      @(posedge i_sys_clk) disable iff (i_reset)
      (!sel_option && !sel_status) |=> (o_attr_rdata == 8'h00);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("Unmapped address returned data.");

   property p_run_keep;
      @(posedge i_sys_clk) disable iff (i_reset)
      (power_state == PCC_RUN && !power_down_request) |=> o_lan_standby_bit;
   endproperty
   a_run_keep: assert property (p_run_keep) else $error("Standby entered without request.");

   property p_standby_only;
      @(posedge i_sys_clk) disable iff (i_reset)
      (power_state == PCC_RUN && power_down_request && !i_shutdown_enable && !soft_reset_bit)
         |=> !o_lan_standby_bit && !o_shutdown;
   endproperty
   a_standby_only: assert property (p_standby_only) else $error("Standby request gave wrong mode.");

   property p_byte_set;
      @(posedge i_sys_clk) disable iff (i_reset)
      (wr_status && !soft_reset_bit && i_attr_wdata[BIT_BYTE_IO]) |=> o_byte_io_select && o_lan_byte_width_bit;
   endproperty
   a_byte_set: assert property (p_byte_set) else $error("Byte mode not selected.");
endmodule // pcc_config_regs

// File: pcc_host_model.sv
// Host socket controller model that runs attribute memory cycles.
`timescale 1ns/10ps
module pcc_host_model (
   input  wire logic        i_sys_clk,
   input  wire logic [7:0]  i_attr_rdata,
   output logic      [10:0] o_attr_addr,
   output logic             o_attr_write,
   output logic      [7:0]  o_attr_wdata
);
   // Any address the caller gives, even or odd, and the low byte only; there is no high byte enable to drive in byte mode.
   initial begin
      o_attr_addr  = 11'h000;
      o_attr_write = 1'h0;
      o_attr_wdata = 8'h00;
   end
   // Idle cycles after a write park on an unmapped address with inverted data so stale values never look valid.
   task automatic wr(input logic [10:0] a, input logic [7:0] d);
      @(negedge i_sys_clk);
      o_attr_addr  = a;
      o_attr_write = 1'h1;
      o_attr_wdata = d;
      @(negedge i_sys_clk);
      o_attr_write = 1'h0;
      o_attr_addr  = 11'h000;
      o_attr_wdata = ~d;
   endtask
   task automatic rd(input logic [10:0] a, output logic [7:0] d);
      @(negedge i_sys_clk);
      o_attr_addr = a;
      @(negedge i_sys_clk);
      d           = i_attr_rdata;
      o_attr_addr = 11'h000;
   endtask
endmodule // pcc_host_model

// File: pcc_config_regs_test.sv
// Self-checking bench for the card configuration registers.
`timescale 1ns/10ps
module pcc_config_regs_test;
   import pcc_pkg::*;
   logic        i_sys_clk;
   logic        i_reset;
   logic        io_mode;
   logic        chg;
   logic        sd_en;
   logic [10:0] addr;
   logic        wr_s;
   logic [7:0]  wdata;
   logic [7:0]  rdata;
   logic        core_rst, width, lan_standby_bit, shut, byte_io;
   logic [5:0]  idx;
   int          fails;
   int          checks;
   pcc_host_model i_pcc_host_model (.i_sys_clk(i_sys_clk), .i_attr_rdata(rdata), .o_attr_addr(addr),
      .o_attr_write(wr_s), .o_attr_wdata(wdata));
   pcc_config_regs i_pcc_config_regs (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_attr_addr(addr),
      .i_attr_write(wr_s), .i_attr_wdata(wdata), .i_io_card_mode(io_mode), .i_ready_busy_change_flag(chg),
      .i_shutdown_enable(sd_en), .o_attr_rdata(rdata), .o_core_reset(core_rst), .o_lan_byte_width_bit(width),
      .o_lan_standby_bit(lan_standby_bit), .o_shutdown(shut), .o_config_index_field(idx), .o_byte_io_select(byte_io));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      i_sys_clk = 1'b0;
      forever #25 i_sys_clk = ~i_sys_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t ns got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [10:0] a, input logic [7:0] exp);
      logic [7:0] d;
      i_pcc_host_model.rd(a, d);
      chk(d, exp);
   endtask
   task automatic test_done();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rchk(ADDR_OPTION, 8'h40);
      rchk(ADDR_STATUS, 8'h00);
      chk({core_rst, width, lan_standby_bit, shut, 4'h0}, 8'h20);
      $display("reset values done");
   endtask
   task automatic t_option();
      i_pcc_host_model.wr(ADDR_OPTION, 8'h6A);
      rchk(ADDR_OPTION, 8'h6A);
      i_pcc_host_model.wr(ADDR_OPTION, 8'h3F);
      rchk(ADDR_OPTION, 8'h7F);
      chk({2'h0, idx}, 8'h3F);
      i_pcc_host_model.wr(11'h7F1, 8'h01);
      rchk(ADDR_OPTION, 8'h7F);
      rchk(11'h7F1, 8'h00);
      $display("option register done");
   endtask
   task automatic t_status();
      i_pcc_host_model.wr(ADDR_STATUS, 8'hDB);
      rchk(ADDR_STATUS, 8'h00);
      chg = 1'h1;
      rchk(ADDR_STATUS, 8'h80);
      chg = 1'h0;
      i_pcc_host_model.wr(ADDR_STATUS, 8'h20);
      rchk(ADDR_STATUS, 8'h20);
      chk({6'h00, width, byte_io}, 8'h03);
      i_pcc_host_model.wr(ADDR_STATUS, 8'h00);
      chk({7'h00, width}, 8'h00);
      $display("status register done");
   endtask
   // Power down is requested here, and again in t_hw_reset, after the registers are set up.
   task automatic t_power();
      i_pcc_host_model.wr(ADDR_STATUS, 8'h04);
      @(negedge i_sys_clk);
      chk({6'h00, lan_standby_bit, shut}, 8'h00);
      rchk(ADDR_STATUS, 8'h04);
      i_pcc_host_model.wr(ADDR_STATUS, 8'h00);
      @(negedge i_sys_clk);
      chk({7'h00, lan_standby_bit}, 8'h01);
      sd_en = 1'h1;
      i_pcc_host_model.wr(ADDR_STATUS, 8'h04);
      @(negedge i_sys_clk);
      chk({6'h00, lan_standby_bit, shut}, 8'h01);
      $display("power down done");
   endtask
   // Shutdown is left only through the soft reset here.
   task automatic t_soft();
      i_pcc_host_model.wr(ADDR_OPTION, 8'h95);
      chk({7'h00, core_rst}, 8'h01);
      i_pcc_host_model.wr(ADDR_STATUS, 8'h24);
      chk({idx, lan_standby_bit, shut}, 8'h02);
      rchk(ADDR_STATUS, 8'h00);
      rchk(ADDR_OPTION, 8'hC0);
      sd_en = 1'h0;
      i_pcc_host_model.wr(ADDR_OPTION, 8'h00);
      chk({core_rst, width, lan_standby_bit, shut, byte_io, 3'h0}, 8'h20);
      rchk(ADDR_OPTION, 8'h40);
      $display("soft reset done");
   endtask
   // A hardware reset in mid-run must also leave shutdown and restore every reset value.
   task automatic t_hw_reset();
      sd_en = 1'h1;
      i_pcc_host_model.wr(ADDR_OPTION, 8'h2A);
      i_pcc_host_model.wr(ADDR_STATUS, 8'h24);
      @(negedge i_sys_clk);
      chk({6'h00, lan_standby_bit, shut}, 8'h01);
      i_reset = 1'h1;
      repeat (2) @(negedge i_sys_clk);
      i_reset = 1'h0;
      sd_en   = 1'h0;
      chk({core_rst, width, lan_standby_bit, shut, byte_io, 3'h0}, 8'h20);
      chk({2'h0, idx}, 8'h00);
      rchk(ADDR_OPTION, 8'h40);
      rchk(ADDR_STATUS, 8'h00);
      $display("hardware reset done");
   endtask
   // Outside I/O card mode the level bit reads 0 and still ignores writes.
   task automatic t_io_mode();
      io_mode = 1'h0;
      rchk(ADDR_OPTION, 8'h00);
      i_pcc_host_model.wr(ADDR_OPTION, 8'h41);
      rchk(ADDR_OPTION, 8'h01);
      io_mode = 1'h1;
      rchk(ADDR_OPTION, 8'h41);
      $display("card mode done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      fails   = 0;
      checks  = 0;
      i_reset = 1'h1;
      io_mode = 1'h1;
      chg     = 1'h0;
      sd_en   = 1'h0;
      repeat (20) @(negedge i_sys_clk);
      i_reset = 1'h0;
      t_reset();
      t_option();
      t_status();
      t_power();
      t_soft();
      t_hw_reset();
      t_io_mode();
      test_done();
   end
   // A hang counts as a mismatch and still reaches the closing report.
   initial begin
      repeat (5000) @(posedge i_sys_clk);
      fails++;
      $display("[FAIL] %0t ns run did not finish in time", $time);
      test_done();
   end
endmodule // pcc_config_regs_test
